// >>> design/dfe_pipe.sv
// Decoupled prefetch and two-pass execute pipeline with result buffer
module dfe_pipe #(
  parameter int unsigned IQ_DEPTH = dfe_pkg::DFE_IQ_DEPTH
) (
  // Clock and reset
  input wire logic I_CORE_CLK,
  input wire logic I_SRST,
  // Instruction fetch bus
  output logic O_IBUS_REQ,
  output dfe_pkg::dfe_word_type O_IBUS_ADDR,
  input wire logic I_IBUS_ACK,
  input wire dfe_pkg::dfe_word_type I_IBUS_RDATA,
  // Operand bus
  output logic O_OBUS_REQ,
  output logic O_OBUS_WE,
  output dfe_pkg::dfe_word_type O_OBUS_ADDR,
  output dfe_pkg::dfe_word_type O_OBUS_WDATA,
  input wire logic I_OBUS_ACK,
  input wire dfe_pkg::dfe_word_type I_OBUS_RDATA,
  // Result stream
  output logic O_RES_VALID,
  output dfe_pkg::dfe_word_type O_RES_DATA,
  input wire logic I_RES_READY,
  // Status
  output dfe_pkg::dfe_word_type O_ACC
);
  import dfe_pkg::*;

  // Prefetch state
  dfe_fc_state_type fc_q, fc_d;
  dfe_word_type fa_q, fa_d;
  dfe_word_type fc_addr_q, fc_addr_d;
  // Decode/operand stage
  logic ds_valid_q, ds_valid_d;
  logic ds_pass2_q, ds_pass2_d;
  dfe_word_type ds_insn_q, ds_insn_d;
  dfe_word_type ds_rdata_q, ds_rdata_d;
  dfe_word_type ds_ea_q, ds_ea_d;
  // Address/execute stage
  logic ex_valid_q, ex_valid_d;
  logic ex_pass2_q, ex_pass2_d;
  dfe_word_type ex_insn_q, ex_insn_d;
  dfe_word_type ex_ea_q, ex_ea_d;
  dfe_word_type ex_val_q, ex_val_d;
  dfe_word_type acc_q, acc_d;
  // Result buffer
  dfe_word_type rb_q [DFE_RB_DEPTH];
  dfe_word_type rb_d [DFE_RB_DEPTH];
  logic [1:0] rb_cnt_q, rb_cnt_d;

  // Queue handshake
  logic iq_push, iq_ready, iq_pop, iq_valid;
  dfe_word_type iq_data;

  // Combinational pipeline controls
  dfe_class_type ex_cls, ds_cls;
  logic ex_bus, ex_we, ex_push, ex_done, ex_ret, ex_free;
  logic ds_adv, ds_block, ds_load, src_valid;
  logic rb_ready, rb_pop;
  dfe_word_type src_data;

  dfe_iq #(
    .W(32),
    .DEPTH(IQ_DEPTH)
  ) u_queue (
    .i_clk(I_CORE_CLK),
    .i_srst(I_SRST),
    .i_push(iq_push),
    .i_data(I_IBUS_RDATA),
    .o_ready(iq_ready),
    .i_pop(iq_pop),
    .o_valid(iq_valid),
    .o_data(iq_data)
  );

  assign O_IBUS_REQ = (fc_q == DFE_FC_BUSY);
  assign O_IBUS_ADDR = fc_addr_q;
  assign O_ACC = acc_q;
  assign O_RES_VALID = (rb_cnt_q != 2'h0);
  assign O_RES_DATA = rb_q[0];
  assign rb_ready = (rb_cnt_q != 2'h2);
  assign rb_pop = O_RES_VALID && I_RES_READY;

  always_comb begin
    ex_cls = dfe_class(ex_insn_q);
    ds_cls = dfe_class(ds_insn_q);
    // Bus needed for stores, first pass of reads, write-back of RMW
    ex_bus = ((ex_cls == DFE_CLS_STORE) || dfe_is_read(ex_insn_q))
      ? !ex_pass2_q : 1'b0;
    if ((ex_cls == DFE_CLS_RMW) && ex_pass2_q) begin
      ex_bus = 1'b1;
    end
    ex_we = (ex_cls == DFE_CLS_STORE) || ((ex_cls == DFE_CLS_RMW) && ex_pass2_q);
    ex_push = (ex_cls == DFE_CLS_REG) || (dfe_is_read(ex_insn_q) && ex_pass2_q);
    // Request only once the result has room, so an ack is never lost
    O_OBUS_REQ = ex_valid_q && ex_bus && (!ex_push || rb_ready);
    O_OBUS_WE = ex_we;
    O_OBUS_ADDR = ex_ea_q;
    O_OBUS_WDATA = ex_val_q;
    ex_done = ex_valid_q && (!ex_bus || (O_OBUS_REQ && I_OBUS_ACK))
      && (!ex_push || rb_ready);
    ex_ret = ex_done && dfe_is_read(ex_insn_q) && !ex_pass2_q;
    ex_free = !ex_valid_q || ex_done;
    ds_adv = ds_valid_q && ex_free;
    // A read in flight owns both stages until its second pass
    ds_block = (ex_valid_q && dfe_is_read(ex_insn_q) && !ex_pass2_q)
      || (ds_adv && dfe_is_read(ds_insn_q) && !ds_pass2_q);
    src_valid = iq_valid || (O_IBUS_REQ && I_IBUS_ACK);
    src_data = iq_valid ? iq_data : I_IBUS_RDATA;
    ds_load = src_valid && !ds_block && (!ds_valid_q || ds_adv);
    iq_pop = iq_valid && ds_load;
    iq_push = O_IBUS_REQ && I_IBUS_ACK && !(!iq_valid && ds_load);
  end

  always_comb begin
    fc_d = fc_q;
    fa_d = fa_q;
    fc_addr_d = fc_addr_q;
    case (fc_q)
      DFE_FC_IDLE: begin
        // Queue room covers the single word in flight
        if (iq_ready) begin
          fc_addr_d = fa_q;
          fa_d = fa_q + DFE_FETCH_STEP;
          fc_d = DFE_FC_BUSY;
        end
      end
      DFE_FC_BUSY: begin
        if (I_IBUS_ACK) begin
          fc_d = DFE_FC_IDLE;
        end
      end
      default: begin
        fc_d = DFE_FC_IDLE;
      end
    endcase
  end

  always_comb begin
    acc_d = acc_q;
    ex_valid_d = ex_valid_q && !ex_done;
    ex_pass2_d = ex_pass2_q;
    ex_insn_d = ex_insn_q;
    ex_ea_d = ex_ea_q;
    ex_val_d = ex_val_q;
    ds_valid_d = ds_valid_q && !ds_adv;
    ds_pass2_d = ds_pass2_q;
    ds_insn_d = ds_insn_q;
    ds_rdata_d = ds_rdata_q;
    ds_ea_d = ds_ea_q;
    // Commit of the execute stage
    if (ex_done && ((ex_cls == DFE_CLS_REG)
        || ((ex_cls == DFE_CLS_LOAD) && ex_pass2_q))) begin
      acc_d = ex_val_q;
    end
    // Second pass goes back through the decode stage
    if (ex_ret) begin
      ds_valid_d = 1'b1;
      ds_pass2_d = 1'b1;
      ds_insn_d = ex_insn_q;
      ds_rdata_d = I_OBUS_RDATA;
      ds_ea_d = ex_ea_q;
    end
    if (ds_adv) begin
      ex_valid_d = 1'b1;
      ex_pass2_d = ds_pass2_q;
      ex_insn_d = ds_insn_q;
      ex_ea_d = ds_pass2_q ? ds_ea_q : (dfe_imm(ds_insn_q) << 2);
      case (ds_cls)
        DFE_CLS_REG: ex_val_d = acc_d + dfe_imm(ds_insn_q);
        DFE_CLS_STORE: ex_val_d = acc_d;
        DFE_CLS_LOAD: ex_val_d = ds_rdata_q;
        DFE_CLS_RMW: ex_val_d = ds_rdata_q + acc_d;
        default: ex_val_d = acc_d;
      endcase
    end
    if (ds_load) begin
      ds_valid_d = 1'b1;
      ds_pass2_d = 1'b0;
      ds_insn_d = src_data;
    end
  end

  // Two-entry result buffer
  always_comb begin
    rb_d = rb_q;
    rb_cnt_d = rb_cnt_q;
    if (rb_pop) begin
      rb_d[0] = rb_q[1];
      rb_cnt_d = rb_cnt_d - 2'h1;
    end
    if (ex_done && ex_push) begin
      rb_d[rb_cnt_d[0]] = ex_val_q;
      rb_cnt_d = rb_cnt_d + 2'h1;
    end
  end

  always_ff @(posedge I_CORE_CLK) begin
    if (I_SRST) begin
      fc_q <= DFE_FC_IDLE;
      fa_q <= DFE_RESET_ADDR;
      fc_addr_q <= DFE_RESET_ADDR;
      ds_valid_q <= 1'b0;
      ds_pass2_q <= 1'b0;
      ds_insn_q <= '0;
      ds_rdata_q <= '0;
      ds_ea_q <= '0;
      ex_valid_q <= 1'b0;
      ex_pass2_q <= 1'b0;
      ex_insn_q <= '0;
      ex_ea_q <= '0;
      ex_val_q <= '0;
      acc_q <= DFE_ACC_RESET;
      rb_q[0] <= '0;
      rb_q[1] <= '0;
      rb_cnt_q <= 2'h0;
    end else begin
      fc_q <= fc_d;
      fa_q <= fa_d;
      fc_addr_q <= fc_addr_d;
      ds_valid_q <= ds_valid_d;
      ds_pass2_q <= ds_pass2_d;
      ds_insn_q <= ds_insn_d;
      ds_rdata_q <= ds_rdata_d;
      ds_ea_q <= ds_ea_d;
      ex_valid_q <= ex_valid_d;
      ex_pass2_q <= ex_pass2_d;
      ex_insn_q <= ex_insn_d;
      ex_ea_q <= ex_ea_d;
      ex_val_q <= ex_val_d;
      acc_q <= acc_d;
      rb_q <= rb_d;
      rb_cnt_q <= rb_cnt_d;
    end
  end

endmodule : dfe_pipe

// >>> common/dfe_pkg.sv
// Shared constants, types and decode helpers of the fetch/execute pipeline
// Behaviour
// - Prefetch path is two stages: address generation, then fetch cycle.
// - Address stage computes the next prefetch address every time it advances.
// - Fetch cycle stage requests the word on the local bus at that address.
// - First execute stage decodes and gathers address parts; second pass carries the operand read on the first pass.
// - Second execute stage forms operand address or executes, by pass.
// - FIFO queue decouples prefetch from execution so fetching runs ahead.
// - Instruction queue stores exactly three longwords.
// - Empty queue: fetched word goes straight into the execute pipeline if decode can load it, else it is queued.
// - Occupied queue: fetched words are queued until execution takes them.
// - Register-register and store instructions pass the execute stages once.
// - Loads and read-modify-writes pass twice: address and read, then complete.
package dfe_pkg;

  typedef logic [31:0] dfe_word_type;
  typedef logic [1:0] dfe_class_type;

  localparam int unsigned DFE_IQ_DEPTH = 3;
  localparam int unsigned DFE_RB_DEPTH = 2;
  localparam dfe_word_type DFE_RESET_ADDR = 32'h0000_0000;
  localparam dfe_word_type DFE_FETCH_STEP = 32'h0000_0004;
  localparam dfe_word_type DFE_ACC_RESET = 32'h0000_0000;

  // Instruction fields
  localparam int unsigned DFE_CLASS_MSB = 31;
  localparam int unsigned DFE_CLASS_LSB = 30;
  localparam int unsigned DFE_IMM_MSB = 15;
  localparam int unsigned DFE_IMM_LSB = 0;

  localparam dfe_class_type DFE_CLS_REG = 2'h0;
  localparam dfe_class_type DFE_CLS_STORE = 2'h1;
  localparam dfe_class_type DFE_CLS_LOAD = 2'h2;
  localparam dfe_class_type DFE_CLS_RMW = 2'h3;

  typedef enum logic [0:0] {
    DFE_FC_IDLE = 1'b0,
    DFE_FC_BUSY = 1'b1
  } dfe_fc_state_type;

  function automatic dfe_class_type dfe_class(input dfe_word_type insn);
    dfe_class = insn[DFE_CLASS_MSB:DFE_CLASS_LSB];
  endfunction : dfe_class

  // Loads and read-modify-writes need a second pass
  function automatic logic dfe_is_read(input dfe_word_type insn);
    dfe_is_read = insn[DFE_CLASS_MSB];
  endfunction : dfe_is_read

  function automatic dfe_word_type dfe_imm(input dfe_word_type insn);
    dfe_imm = {16'h0000, insn[DFE_IMM_MSB:DFE_IMM_LSB]};
  endfunction : dfe_imm

endpackage : dfe_pkg

// >>> design/dfe_iq.sv
// Instruction queue storage: small FIFO with head word held in registers
module dfe_iq #(
  parameter int unsigned W = 32,
  parameter int unsigned DEPTH = 3
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_srst,
  // Fill side
  input wire logic i_push,
  input wire logic [W-1:0] i_data,
  output logic o_ready,
  // Drain side
  input wire logic i_pop,
  output logic o_valid,
  output logic [W-1:0] o_data
);
  localparam int unsigned PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int unsigned CW = $clog2(DEPTH + 1);

  logic [W-1:0] mem_q [DEPTH];
  logic [PW-1:0] wr_q, wr_d, rd_q, rd_d;
  logic [CW-1:0] cnt_q, cnt_d;
  logic do_push, do_pop;

  assign o_ready = (cnt_q != CW'(DEPTH));
  assign o_valid = (cnt_q != '0);
  assign o_data = mem_q[rd_q];
  assign do_push = i_push && o_ready;
  assign do_pop = i_pop && o_valid;

  always_comb begin
    wr_d = wr_q;
    rd_d = rd_q;
    cnt_d = cnt_q;
    if (do_push) begin
      wr_d = (wr_q == PW'(DEPTH - 1)) ? '0 : wr_q + 1'b1;
    end
    if (do_pop) begin
      rd_d = (rd_q == PW'(DEPTH - 1)) ? '0 : rd_q + 1'b1;
    end
    if (do_push && !do_pop) begin
      cnt_d = cnt_q + 1'b1;
    end else if (do_pop && !do_push) begin
      cnt_d = cnt_q - 1'b1;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
    end else begin
      wr_q <= wr_d;
      rd_q <= rd_d;
      cnt_q <= cnt_d;
    end
  end

  // Storage needs no reset: empty count masks stale words
  always_ff @(posedge i_clk) begin
    if (do_push) begin
      mem_q[wr_q] <= i_data;
    end
  end

endmodule : dfe_iq

// >>> testbench/dfe_pipe_props.sv
// Port timing checker of the pipeline
module dfe_pipe_props #(
  parameter int unsigned IQ_DEPTH = 3
) (
  // Clock and reset
  input wire logic I_CORE_CLK,
  input wire logic I_SRST,
  // Fetch bus
  input wire logic O_IBUS_REQ,
  input wire dfe_pkg::dfe_word_type O_IBUS_ADDR,
  input wire logic I_IBUS_ACK,
  // Operand bus
  input wire logic O_OBUS_REQ,
  input wire logic O_OBUS_WE,
  input wire dfe_pkg::dfe_word_type O_OBUS_ADDR,
  input wire dfe_pkg::dfe_word_type O_OBUS_WDATA,
  input wire logic I_OBUS_ACK,
  // Result stream
  input wire logic O_RES_VALID,
  input wire dfe_pkg::dfe_word_type O_RES_DATA,
  input wire logic I_RES_READY,
  input wire dfe_pkg::dfe_word_type O_ACC
);
  timeunit 1ns;
  timeprecision 1ps;
  import dfe_pkg::*;
  dfe_word_type next_q;
  always_ff @(posedge I_CORE_CLK) begin
    if (I_SRST) next_q <= DFE_RESET_ADDR;
    else if (O_IBUS_REQ && I_IBUS_ACK)
      next_q <= O_IBUS_ADDR + DFE_FETCH_STEP;
  end
  default clocking @(posedge I_CORE_CLK); endclocking
  default disable iff (I_SRST);
  rst_idle_a: assert property (disable iff (1'b0) I_SRST |=> !O_IBUS_REQ
    && !O_OBUS_REQ && !O_RES_VALID && O_ACC == DFE_ACC_RESET)
    else $error("state not cleared");
  first_fetch_a: assert property ($fell(I_SRST) |->
    !O_IBUS_REQ ##1 O_IBUS_REQ && O_IBUS_ADDR == DFE_RESET_ADDR)
    else $error("no first fetch");
  fetch_hold_a: assert property (O_IBUS_REQ && !I_IBUS_ACK |=>
    O_IBUS_REQ && $stable(O_IBUS_ADDR)) else $error("fetch dropped");
  fetch_gap_a: assert property (O_IBUS_REQ && I_IBUS_ACK |=> !O_IBUS_REQ)
    else $error("no idle cycle");
  fetch_addr_a: assert property ($rose(O_IBUS_REQ) |-> O_IBUS_ADDR == next_q)
    else $error("bad fetch address");
  op_hold_a: assert property (O_OBUS_REQ && !I_OBUS_ACK |=> O_OBUS_REQ
    && $stable(O_OBUS_WE) && $stable(O_OBUS_ADDR) && $stable(O_OBUS_WDATA))
    else $error("operand request changed");
  res_hold_a: assert property (O_RES_VALID && !I_RES_READY |=> O_RES_VALID
    && $stable(O_RES_DATA)) else $error("result changed");
  write_acc_a: assert property (O_OBUS_REQ && O_OBUS_WE |=> $stable(O_ACC))
    else $error("accumulator changed");
  load_c: cover property (O_OBUS_REQ && !O_OBUS_WE && I_OBUS_ACK);
  write_c: cover property (O_OBUS_REQ && O_OBUS_WE && I_OBUS_ACK);
  stall_c: cover property ((O_RES_VALID && !I_RES_READY) [*4]);
endmodule : dfe_pipe_props

// >>> testbench/dfe_mem_model.sv
// Local bus memory model with a set answer delay
module dfe_mem_model (
  // Clock and delay
  input wire logic i_clk,
  input wire logic [3:0] i_lat,
  // Fetch bus
  input wire logic i_ireq,
  input wire dfe_pkg::dfe_word_type i_iaddr,
  output logic o_iack,
  output dfe_pkg::dfe_word_type o_irdata,
  // Operand bus
  input wire logic i_oreq,
  input wire logic i_owe,
  input wire dfe_pkg::dfe_word_type i_oaddr,
  input wire dfe_pkg::dfe_word_type i_owdata,
  output logic o_oack,
  output dfe_pkg::dfe_word_type o_ordata
);
  timeunit 1ns;
  timeprecision 1ps;
  import dfe_pkg::*;
  dfe_word_type imem [64];
  dfe_word_type dmem [64];
  dfe_word_type ilast_q = '0;
  dfe_word_type olast_q = '0;
  logic [3:0] icnt_q = 4'h0;
  logic [3:0] ocnt_q = 4'h0;
  // Data outside an ack is the last released word inverted, so stale words never pass
  assign o_iack = i_ireq && icnt_q >= i_lat;
  assign o_oack = i_oreq && ocnt_q >= i_lat;
  assign o_irdata = o_iack ? imem[i_iaddr[7:2]] : ~ilast_q;
  assign o_ordata = o_oack ? dmem[i_oaddr[7:2]] : ~olast_q;
  always @(posedge i_clk) begin
    icnt_q <= (i_ireq && !o_iack) ? icnt_q + 4'h1 : 4'h0;
    ocnt_q <= (i_oreq && !o_oack) ? ocnt_q + 4'h1 : 4'h0;
    if (o_iack) ilast_q <= o_irdata;
    if (o_oack) olast_q <= o_ordata;
    if (o_oack && i_owe) dmem[i_oaddr[7:2]] <= i_owdata;
  end
endmodule : dfe_mem_model

// >>> testbench/dfe_pipe_bench.sv
// Bench of the pipeline with memory model and result sink
module dfe_pipe_bench;
  timeunit 1ns;
  timeprecision 1ps;
  import dfe_pkg::*;
  typedef struct packed {
    dfe_word_type insn;
    logic has_res;
    dfe_word_type res;
  } dfe_row_type;
  localparam int NROWS = 7;
  localparam dfe_row_type ROWS [NROWS] = '{
    '{32'h0000_0005, 1'b1, 32'h0000_0005},
    '{32'h4000_0002, 1'b0, 32'h0000_0000},
    '{32'h0000_0003, 1'b1, 32'h0000_0008},
    '{32'h8000_0001, 1'b1, 32'h0000_1000},
    '{32'hC000_0002, 1'b1, 32'h0000_1005},
    '{32'h0000_FFFF, 1'b1, 32'h0001_0FFF},
    '{32'h8000_0002, 1'b1, 32'h0000_1005}
  };
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic ready = 1'b0;
  logic [3:0] lat = 4'h0;
  logic ireq, iack, oreq, owe, oack, rvalid;
  dfe_word_type iaddr, irdata, oaddr, owdata, ordata, rdata, acc;
  int errors = 0;
  int samples_checked = 0;
  int fetches = 0;

  always #10 clk = ~clk;

  // Fetch completions since the last reset
  always @(posedge clk) begin
    if (srst) fetches <= 0;
    else if (ireq && iack) fetches <= fetches + 1;
  end

  dfe_pipe dut (.I_CORE_CLK(clk), .I_SRST(srst),
    .O_IBUS_REQ(ireq), .O_IBUS_ADDR(iaddr), .I_IBUS_ACK(iack),
    .I_IBUS_RDATA(irdata), .O_OBUS_REQ(oreq), .O_OBUS_WE(owe),
    .O_OBUS_ADDR(oaddr), .O_OBUS_WDATA(owdata), .I_OBUS_ACK(oack),
    .I_OBUS_RDATA(ordata), .O_RES_VALID(rvalid), .O_RES_DATA(rdata),
    .I_RES_READY(ready), .O_ACC(acc));
  dfe_mem_model mem (.i_clk(clk), .i_lat(lat), .i_ireq(ireq),
    .i_iaddr(iaddr), .o_iack(iack), .o_irdata(irdata), .i_oreq(oreq),
    .i_owe(owe), .i_oaddr(oaddr), .i_owdata(owdata), .o_oack(oack),
    .o_ordata(ordata));

  task automatic give_verdict();
    $display("checks %0d errors %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : give_verdict

  task automatic check(input dfe_word_type got, input dfe_word_type exp);
    samples_checked++;
    if (got !== exp) begin
      errors++;
      $display("mismatch at %0t got %h exp %h", $time, got, exp);
    end
  endtask : check

  // Takes one result; the sink stalls between calls
  task automatic get_res(output dfe_word_type d);
    int n;
    n = 0;
    while (rvalid !== 1'b1 && n < 300) begin
      @(negedge clk);
      n++;
    end
    if (n >= 300) begin
      errors++;
      give_verdict();
    end
    d = rdata;
    ready = 1'b1;
    @(negedge clk);
    ready = 1'b0;
    @(negedge clk);
  endtask : get_res

  initial begin
    dfe_word_type d;
    int acks;
    for (int i = 0; i < 64; i++) mem.imem[i] = 32'h0000_0001;
    for (int i = 0; i < NROWS; i++) mem.imem[i] = ROWS[i].insn;
    mem.dmem[1] = 32'h0000_1000;
    repeat (6) @(negedge clk);
    srst = 1'b0;
    for (int i = 0; i < NROWS; i++) begin
      if (ROWS[i].has_res) begin
        get_res(d);
        check(d, ROWS[i].res);
      end
    end
    check(mem.dmem[2], 32'h0000_1005);
    // Slow memory and a stalled sink must halt fetching
    lat = 4'h2;
    acks = 0;
    for (int i = 0; i < 80; i++) begin
      @(negedge clk);
      if (i >= 40 && ireq && iack) acks++;
    end
    check(32'(acks), 32'h0);
    check(32'(rvalid), 32'h1);
    // Seven retired, two buffered, one per stage, a full queue
    check(32'(fetches), 32'(11 + DFE_IQ_DEPTH));
    check(acc, 32'h0000_1007);
    for (int k = 0; k < 10; k++) begin
      get_res(d);
      check(d, 32'h0000_1006 + 32'(k));
    end
    srst = 1'b1;
    repeat (2) @(negedge clk);
    check(acc, DFE_ACC_RESET);
    check(32'(rvalid), 32'h0);
    srst = 1'b0;
    lat = 4'h1;
    get_res(d);
    check(d, 32'h0000_0005);
    give_verdict();
  end

  initial begin
    #1000000;
    errors++;
    give_verdict();
  end
endmodule : dfe_pipe_bench

bind dfe_pipe dfe_pipe_props #(.IQ_DEPTH(IQ_DEPTH)) props (
  .I_CORE_CLK(I_CORE_CLK), .I_SRST(I_SRST), .O_IBUS_REQ(O_IBUS_REQ),
  .O_IBUS_ADDR(O_IBUS_ADDR), .I_IBUS_ACK(I_IBUS_ACK),
  .O_OBUS_REQ(O_OBUS_REQ), .O_OBUS_WE(O_OBUS_WE),
  .O_OBUS_ADDR(O_OBUS_ADDR), .O_OBUS_WDATA(O_OBUS_WDATA),
  .I_OBUS_ACK(I_OBUS_ACK), .O_RES_VALID(O_RES_VALID),
  .O_RES_DATA(O_RES_DATA), .I_RES_READY(I_RES_READY), .O_ACC(O_ACC));
